// ==== src/auto_serial_buffer_transmit.sv ====
// Purpose: automatic buffered serial transmit unit with cpu register port
// Assumes: serial clock comes from the partner, idle high, sampled by clk
// Notes: msb first, data changes after falling edge, partner samples on rising edge
`timescale 1ns/10ps

// Functional notes
// - eight-bit end pointer register selects last buffer byte sent.
// - end pointer range 00h to 1fh over a 32-byte buffer.
// - transfer starts at fa00h and runs up to end pointer inclusive.
// - repeat select set makes the transfer wrap to the base forever.
// - start bit with unit, auto and transmit enables set starts sending.
// - bytes leave the shifter one bit at a time, eight bits per byte.
// - final byte shifted out sets the completion flag.
// - busy status bit shows whether automatic sending still runs.
// - data input pin stays a plain port pin when unused.
// - a gap follows each byte except the final byte of a single transfer, while the next byte is fetched.
// - gap length comes from the interval register.
// - cpu buffer access during a fetch may stretch the gap.
// - cpu writes to the buffer may see a wait state.
module auto_serial_buffer_transmit
  import auto_serial_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata_q,
  output logic cpu_wait_q,
  input wire logic irq_flag_clr,
  output logic auto_xfer_irq_flag_q,
  input wire logic sck_in,
  output logic sdo_q,
  output logic sdo_oe_q,
  input wire logic data_pin_i,
  output logic data_pin_o_q,
  output logic data_pin_oe_q
);

  logic [7:0] mode_q;
  logic [4:0] end_ptr_q;
  logic [7:0] interval_q;
  logic [1:0] port_q;
  logic in_prog_q;
  logic [7:0] ram [RAM_DEPTH];
  logic [4:0] idx_q;
  logic fetch_on_q;
  shift_state_e state_q;
  shift_state_e state_d;
  logic [7:0] shreg_q;
  logic [2:0] bit_cnt_q;
  logic rose_q;
  logic last_q;
  logic [7:0] gap_cnt_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic pin_s1_q, pin_s2_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_raw;
  logic [7:0] rd_val;

  // address decode
  wire logic hit_end = cpu_addr == OFS_END_PTR;
  wire logic hit_mode = cpu_addr == OFS_MODE;
  wire logic hit_stat = cpu_addr == OFS_STATUS;
  wire logic hit_trig = cpu_addr == OFS_TRIG;
  wire logic hit_intv = cpu_addr == OFS_INTERVAL;
  wire logic hit_port = cpu_addr == OFS_PORT;
  wire logic hit_ram = cpu_addr[15:RAM_AW] == RAM_BASE[15:RAM_AW];
  wire logic cpu_ram_acc = hit_ram & (cpu_wr | cpu_rd);

  // mode fields
  wire logic unit_en = mode_q[MODE_UNIT_EN_BIT];
  wire logic auto_xfer_enable = mode_q[MODE_AUTO_EN_BIT];
  wire logic repeat_xfer_select = mode_q[MODE_REPEAT_BIT];
  wire logic tx_en = mode_q[MODE_TX_EN_BIT];
  wire logic all_en = unit_en & auto_xfer_enable & tx_en;

  // start on trigger with all enables
  wire logic start_req = cpu_wr & hit_trig & cpu_wdata[TRIG_START_BIT] & all_en
    & !in_prog_q & (state_q == ST_IDLE);
  wire logic abort = in_prog_q & !all_en;

  // serial clock edges, first stage read only by second
  wire logic sck_rise = sck_s2_q & !sck_s3_q;
  wire logic sck_fall = !sck_s2_q & sck_s3_q;

  // eighth rising edge finishes the byte
  wire logic byte_done = (state_q == ST_SHIFT) & sck_rise & (bit_cnt_q == LAST_BIT);
  wire logic last_done = byte_done & last_q;

  // fetch yields to any cpu buffer access
  wire logic fetch_go = fetch_on_q & fifo_in_ready & !cpu_ram_acc;
  // end compare on the address counter
  wire logic fetch_end = idx_q == end_ptr_q;

  wire xfer_word_s fetch_word = '{last: fetch_end, data: ram[idx_q]};
  wire xfer_word_s head_word = xfer_word_s'(fifo_out_raw);
  wire logic pop = (state_q == ST_LOAD) & fifo_out_valid & !abort;

  // prefetch buffer between ram and shifter
  xfer_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(start_req | abort),
    .in_valid(fetch_go),
    .in_ready(fifo_in_ready),
    .in_data(fetch_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_raw)
  );

  // input synchronisers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      pin_s1_q <= data_pin_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // register writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RST;
      end_ptr_q <= END_PTR_RST[4:0];
      interval_q <= INTERVAL_RST;
      port_q <= PORT_RST;
    end else if (cpu_wr) begin
      if (hit_mode) mode_q <= cpu_wdata;
      // end pointer kept in low five bits
      if (hit_end) end_ptr_q <= cpu_wdata[4:0];
      if (hit_intv) interval_q <= cpu_wdata;
      if (hit_port) port_q <= cpu_wdata[1:0];
    end
  end

  // buffer ram, cpu side write
  always_ff @(posedge clk) begin
    if (cpu_wr & hit_ram) ram[cpu_addr[RAM_AW-1:0]] <= cpu_wdata;
  end

  // read mux
  always_comb begin
    rd_val = 8'h00;
    if (hit_mode) rd_val = mode_q;
    if (hit_end) rd_val = {3'h0, end_ptr_q};
    if (hit_intv) rd_val = interval_q;
    if (hit_stat) rd_val = {6'h00, auto_xfer_irq_flag_q, in_prog_q};
    if (hit_port) rd_val = {5'h00, pin_s2_q, port_q};
    if (hit_ram) rd_val = ram[cpu_addr[RAM_AW-1:0]];
  end

  // read data and wait strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata_q <= 8'h00;
      cpu_wait_q <= 1'b0;
    end else begin
      if (cpu_rd) cpu_rdata_q <= rd_val;
      // wait when a buffer write collides with a pending fetch
      cpu_wait_q <= cpu_wr & hit_ram & fetch_on_q & fifo_in_ready;
    end
  end

  // busy status and completion flag, set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_prog_q <= 1'b0;
      auto_xfer_irq_flag_q <= 1'b0;
    end else begin
      if (start_req) in_prog_q <= 1'b1;
      else if (abort) in_prog_q <= 1'b0;
      // single mode ends after the final byte
      else if (last_done & !repeat_xfer_select) in_prog_q <= 1'b0;
      auto_xfer_irq_flag_q <= last_done | (auto_xfer_irq_flag_q & !irq_flag_clr);
    end
  end

  // address counter from base through end pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= 5'h00;
      fetch_on_q <= 1'b0;
    end else if (start_req) begin
      idx_q <= 5'h00;
      fetch_on_q <= 1'b1;
    end else if (abort) begin
      fetch_on_q <= 1'b0;
    end else if (fetch_go) begin
      // wrap to base in repeat mode
      idx_q <= fetch_end ? 5'h00 : idx_q + 5'h01;
      if (fetch_end & !repeat_xfer_select) fetch_on_q <= 1'b0;
    end
  end

  // shifter next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start_req) state_d = ST_LOAD;
      ST_LOAD: if (pop) state_d = ST_SHIFT;
      ST_SHIFT: if (byte_done) state_d = (last_q & !repeat_xfer_select) ? ST_IDLE : ST_GAP;
      // gap lasts interval plus one cycle
      ST_GAP: if (gap_cnt_q == interval_q) state_d = ST_LOAD;
      default: state_d = ST_IDLE;
    endcase
    if (abort) state_d = ST_IDLE;
  end

  // shifter, gap counter and serial output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      shreg_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      rose_q <= 1'b0;
      last_q <= 1'b0;
      gap_cnt_q <= 8'h00;
      sdo_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gap_cnt_q <= (state_q == ST_GAP) ? gap_cnt_q + 8'h01 : 8'h00;
      if (pop) begin
        shreg_q <= head_word.data;
        sdo_q <= head_word.data[7];
        last_q <= head_word.last;
        bit_cnt_q <= 3'h0;
        rose_q <= 1'b0;
      end else if (state_q == ST_SHIFT) begin
        // count rising edges, shift on the following fall
        if (sck_rise) begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          rose_q <= 1'b1;
        end else if (sck_fall & rose_q) begin
          shreg_q <= {shreg_q[6:0], 1'b0};
          sdo_q <= shreg_q[6];
          rose_q <= 1'b0;
        end
      end
    end
  end

  // serial output enable, and data input pin as plain port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdo_oe_q <= 1'b0;
      data_pin_o_q <= 1'b0;
      data_pin_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= unit_en & tx_en;
      data_pin_o_q <= port_q[PORT_OUT_BIT];
      data_pin_oe_q <= port_q[PORT_OE_BIT];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_start;
    start_req |=> in_prog_q && state_q == ST_LOAD && fetch_on_q && idx_q == 5'h00;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_no_start;
    (cpu_wr && hit_trig && !all_en && !in_prog_q) |=> !in_prog_q;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start without enables");

  property p_irq;
    last_done |=> auto_xfer_irq_flag_q;
  endproperty
  a_irq: assert property (p_irq) else $error("completion flag missing");

  property p_single_end;
    (last_done && !repeat_xfer_select && !start_req) |=> !in_prog_q && state_q == ST_IDLE;
  endproperty
  a_single_end: assert property (p_single_end) else $error("busy stuck after end");

  property p_wrap;
    (fetch_go && fetch_end && !start_req && !abort) |=> idx_q == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_step;
    (fetch_go && !fetch_end && !start_req && !abort) |=> idx_q == $past(idx_q) + 5'h01;
  endproperty
  a_step: assert property (p_step) else $error("counter step wrong");

  property p_gap;
    (state_q == ST_GAP && gap_cnt_q != interval_q && !abort) |=> state_q == ST_GAP;
  endproperty
  a_gap: assert property (p_gap) else $error("gap cut short");

  property p_yield;
    cpu_ram_acc |-> !fetch_go;
  endproperty
  a_yield: assert property (p_yield) else $error("fetch beat cpu access");

  property p_wait;
    (cpu_wr && hit_ram && fetch_on_q && fifo_in_ready) |=> cpu_wait_q;
  endproperty
  a_wait: assert property (p_wait) else $error("wait missing");

  property p_end_read;
    (cpu_rd && hit_end) |=> cpu_rdata_q[7:5] == 3'h0 && cpu_rdata_q[4:0] == $past(end_ptr_q);
  endproperty
  a_end_read: assert property (p_end_read) else $error("end pointer readback");

  property p_pin;
    port_q == $past(port_q) |=> {data_pin_oe_q, data_pin_o_q} == $past(port_q);
  endproperty
  a_pin: assert property (p_pin) else $error("port pin mismatch");

  c_single: cover property (last_done && !repeat_xfer_select);
  c_repeat: cover property (fetch_go && fetch_end && repeat_xfer_select);
  c_collide: cover property (cpu_ram_acc && fetch_on_q && fifo_in_ready);
  c_full: cover property (fetch_on_q && !fifo_in_ready);

endmodule : auto_serial_buffer_transmit

// ==== src/auto_serial_pkg.sv ====
// Purpose: shared constants and types for the automatic serial transmit block
// Assumes: 8-bit cpu data path, 16-bit cpu addresses
// Notes: only the end pointer address is fixed by the device; other offsets are local picks
package auto_serial_pkg;

  // cpu register addresses
  localparam logic [15:0] OFS_END_PTR = 16'hff94;
  localparam logic [15:0] OFS_MODE = 16'hff90;
  localparam logic [15:0] OFS_STATUS = 16'hff91;
  localparam logic [15:0] OFS_TRIG = 16'hff92;
  localparam logic [15:0] OFS_INTERVAL = 16'hff95;
  localparam logic [15:0] OFS_PORT = 16'hff96;

  // buffer ram window
  localparam logic [15:0] RAM_BASE = 16'hfa00;
  localparam int RAM_DEPTH = 32;
  localparam int RAM_AW = 5;

  // mode, trigger, status and port register bits
  localparam int MODE_UNIT_EN_BIT = 7;
  localparam int MODE_AUTO_EN_BIT = 6;
  localparam int MODE_REPEAT_BIT = 5;
  localparam int MODE_TX_EN_BIT = 3;
  localparam int TRIG_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int PORT_OUT_BIT = 0;
  localparam int PORT_OE_BIT = 1;
  localparam int PORT_IN_BIT = 2;

  // reset values
  localparam logic [7:0] END_PTR_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] INTERVAL_RST = 8'h00;
  localparam logic [1:0] PORT_RST = 2'h0;

  // counts
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int FIFO_DEPTH = 16;

  // shifter states, gray along idle-load-shift-gap
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b11,
    ST_GAP = 2'b10
  } shift_state_e;

  // one buffered byte and its end marker
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } xfer_word_s;

  localparam int WORD_W = $bits(xfer_word_s);

endpackage : auto_serial_pkg

// ==== src/xfer_fifo.sv ====
// Purpose: synchronous fifo between buffer fetch and shifter
// Assumes: single clock, flush clears contents
// Notes: in_ready low when full, out_valid low when empty
`timescale 1ns/10ps
module xfer_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;

  // full when pointers differ only in the wrap bit
  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];

  // pointer update
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + (AW+1)'(1);
      if (pop) rd_q <= rd_q + (AW+1)'(1);
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end

endmodule : xfer_fifo

// ==== dv/serial_peer.sv ====
// Purpose: behavioural serial peripheral that clocks bytes out of the unit
// Assumes: clock idles high, data sampled on the rising edge, msb first
// Notes: the clock stands high between requested bytes
`timescale 1ns/10ps
module serial_peer (
  input wire logic req,
  input wire logic sdo,
  output logic sck,
  output logic ack,
  output logic [7:0] rx_byte
);
  initial begin
    sck = 1'b1;
    ack = 1'b0;
    rx_byte = 8'h00;
  end

  // one byte per request at 400 ns per bit
  // eight rising edges per byte
  always begin
    wait (req);
    for (int i = 0; i < 8; i++) begin
      sck = 1'b0;
      #200;
      sck = 1'b1;
      rx_byte = {rx_byte[6:0], sdo};
      #200;
    end
    ack = 1'b1;
    wait (!req);
    ack = 1'b0;
  end
endmodule : serial_peer

// ==== dv/testbench.sv ====
// Purpose: self-checking bench for the automatic serial transmit unit
// Assumes: cpu strobes change at the falling clk edge
// Notes: serial bytes are checked through an expectation queue
`timescale 1ns/10ps
module testbench;
  import auto_serial_pkg::*;
  localparam logic [7:0] M_TX = (8'h01 << MODE_UNIT_EN_BIT) | (8'h01 << MODE_AUTO_EN_BIT)
    | (8'h01 << MODE_TX_EN_BIT);
  localparam logic [7:0] M_RPT = M_TX | (8'h01 << MODE_REPEAT_BIT);
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic irq_flag_clr = 1'b0;
  logic data_pin_i = 1'b0;
  logic req = 1'b0;
  logic [7:0] cpu_rdata_q, rx_byte, rd_v;
  logic cpu_wait_q, auto_xfer_irq_flag_q, sck, ack, sdo_q, sdo_oe_q;
  logic data_pin_o_q, data_pin_oe_q;
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] exp_q [$];
  int bad_count = 0;
  int n_checks = 0;
  int gap = 0;

  always #25 clk = ~clk;

  auto_serial_buffer_transmit dut_u (.clk(clk), .rstn(rstn), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q),
    .cpu_wait_q(cpu_wait_q), .irq_flag_clr(irq_flag_clr),
    .auto_xfer_irq_flag_q(auto_xfer_irq_flag_q), .sck_in(sck), .sdo_q(sdo_q),
    .sdo_oe_q(sdo_oe_q), .data_pin_i(data_pin_i), .data_pin_o_q(data_pin_o_q),
    .data_pin_oe_q(data_pin_oe_q));

  serial_peer peer_u (.req(req), .sdo(sdo_q), .sck(sck), .ack(ack), .rx_byte(rx_byte));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask : wr

  // read data is registered, settled one edge after the strobe
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    rd_v = cpu_rdata_q;
  endtask : rd

  // clock one byte through the peer, then let the gap pass
  task automatic byte_out(input logic [7:0] e);
    int k;
    exp_q.push_back(e);
    req = 1'b1;
    k = 0;
    while (ack !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k >= 200) begin
      bad_count++;
      final_report();
    end
    req = 1'b0;
    repeat (gap + 8) @(negedge clk);
  endtask : byte_out

  // compare each received byte with the oldest expectation
  always @(posedge ack) begin
    if (exp_q.size() > 0) begin
      check(rx_byte, exp_q.pop_front());
    end else begin
      check(rx_byte, 8'hxx);
    end
  end

  initial begin
    logic [7:0] e;
    void'($urandom(77991));
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    // reset values and an unmapped read
    rd(OFS_END_PTR);
    check(rd_v, END_PTR_RST);
    rd(OFS_MODE);
    check(rd_v, MODE_RST);
    rd(OFS_INTERVAL);
    check(rd_v, INTERVAL_RST);
    rd(OFS_STATUS);
    check(rd_v, 8'h00);
    rd(16'hff9f);
    check(rd_v, 8'h00);
    wr(OFS_END_PTR, 8'h1f);
    rd(OFS_END_PTR);
    check(rd_v, 8'h1f);
    // fill the buffer with random bytes
    for (int i = 0; i < RAM_DEPTH; i++) begin
      ram[i] = 8'($urandom());
      wr(RAM_BASE + 16'(i), ram[i]);
    end
    rd(RAM_BASE + 16'h001f);
    check(rd_v, ram[31]);
    // start refused without transmit enable
    wr(OFS_MODE, M_TX & ~(8'h01 << MODE_TX_EN_BIT));
    wr(OFS_TRIG, 8'h01);
    rd(OFS_STATUS);
    check(rd_v, 8'h00);
    // single mode at both pointer extremes and one random
    for (int t = 0; t < 3; t++) begin
      e = (t == 0) ? 8'h00 : (t == 1) ? 8'h1f : 8'($urandom_range(30, 1));
      gap = $urandom_range(6, 0);
      wr(OFS_END_PTR, e);
      wr(OFS_INTERVAL, 8'(gap));
      wr(OFS_MODE, M_TX);
      wr(OFS_TRIG, 8'h01);
      // buffer write during prefetch, same byte kept
      wr(RAM_BASE + 16'h001f, ram[31]);
      check({7'h0, cpu_wait_q}, {7'h0, t != 0});
      check({7'h0, sdo_oe_q}, 8'h01);
      rd(OFS_STATUS);
      check(rd_v, 8'h01);
      for (int i = 0; i <= int'(e); i++) begin
        byte_out(ram[i]);
      end
      rd(OFS_STATUS);
      check(rd_v, 8'h02);
      check({7'h0, auto_xfer_irq_flag_q}, 8'h01);
      @(negedge clk);
      irq_flag_clr = 1'b1;
      @(negedge clk);
      irq_flag_clr = 1'b0;
      @(negedge clk);
      check({7'h0, auto_xfer_irq_flag_q}, 8'h00);
    end
    // repeat mode wraps, cpu reads the buffer meanwhile
    wr(OFS_END_PTR, 8'h01);
    wr(OFS_MODE, M_RPT);
    wr(OFS_TRIG, 8'h01);
    for (int i = 0; i < 5; i++) begin
      byte_out(ram[i % 2]);
      rd(RAM_BASE + 16'(i % 2));
      check(rd_v, ram[i % 2]);
    end
    check({7'h0, auto_xfer_irq_flag_q}, 8'h01);
    // clearing the mode aborts a running transfer
    wr(OFS_MODE, 8'h00);
    rd(OFS_STATUS);
    check(rd_v, 8'h02);
    // data input pin stays a plain port pin
    data_pin_i = 1'($urandom());
    wr(OFS_PORT, 8'h03);
    repeat (3) @(negedge clk);
    rd(OFS_PORT);
    check(rd_v, {5'h0, data_pin_i, 2'h3});
    check({6'h0, data_pin_oe_q, data_pin_o_q}, 8'h03);
    final_report();
  end
endmodule : testbench
